// ### src/psh_controller.v
// Host controller that programs a core's performance state registers.
// Assumes a device register port with a held request and one-cycle ack,
// and software on an APB bus driving the controller's own registers.
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
`include "psh_defs.vh"

module psh_controller (
    input  wire        ref_clk,
    input  wire        resetn,
    input  wire        clkEn,
    input  wire [11:0] paddr,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    output reg         devReq,
    output reg         devWrite,
    output reg  [31:0] devAddr,
    output reg  [63:0] devWdata,
    input  wire [63:0] devRdata,
    input  wire        devAck
);

    localparam [2:0] ST_IDLE  = 3'h0;
    localparam [2:0] ST_CORE1 = 3'h1;
    localparam [2:0] ST_REQEN = 3'h2;
    localparam [2:0] ST_CLKTM = 3'h3;
    localparam [2:0] ST_READ  = 3'h4;
    localparam [2:0] ST_WRITE = 3'h5;

    reg  [2:0]  state;
    reg         mpSys;
    reg         dualCore;
    reg         revG;
    reg         osDone;
    reg  [5:0]  tgtFreq;
    reg  [4:0]  tgtVolt;
    reg  [5:0]  minCode;
    reg  [19:0] sgCount;
    reg         busy;
    reg         done;
    reg         refused;
    reg  [5:0]  presFreq;
    reg  [4:0]  presVolt;
    reg  [63:0] next_ctl;

    wire        apbAcc  = psel & penable & pready;
    wire        apbWr   = apbAcc & pwrite;
    wire        goPulse = apbWr & (paddr == `PSH_OFF_CTRL) &
                          pwdata[`PSH_CTRL_GO];
    // Settings carried by the go write itself apply to that go
    wire        goMp    = pwdata[`PSH_CTRL_MP];
    wire        goDual  = pwdata[`PSH_CTRL_DUAL];
    wire        goRevG  = pwdata[`PSH_CTRL_REVG];
    wire        goOs    = osDone | pwdata[`PSH_CTRL_OSDONE];
    wire [5:0]  curF    = devRdata[5:0];
    wire [4:0]  curV    = devRdata[36:32];

    // Oscillator frequency of a code in 100 MHz units
    function [6:0] vco;
        input [5:0] c;
        begin
            if (c < `PSH_HIGH_FIRST)
                vco = ({1'b0, c} + `PSH_VCO_OFFSET) << 1;
            else
                vco = {1'b0, c} + `PSH_VCO_OFFSET;
        end
    endfunction

    // Next code on the way to t, at most one 200 MHz oscillator step
    function [5:0] stepTo;
        input [5:0] c;
        input [5:0] t;
        reg   [6:0] vc;
        reg   [6:0] vt;
        reg   [6:0] nx;
        begin
            vc = vco(c);
            vt = vco(t);
            nx = {1'b0, t};
            if (vt > vc + `PSH_VCO_STEP)
                nx = vc + `PSH_VCO_STEP - `PSH_VCO_OFFSET;
            else if (vt + `PSH_VCO_STEP < vc)
                nx = vc - `PSH_VCO_STEP - `PSH_VCO_OFFSET;
            stepTo = nx[5:0];
        end
    endfunction

    // Target code legality
    function codeOk;
        input [5:0] t;
        input [5:0] m;
        input       g;
        begin
            codeOk = 1'b1;
            if (t > `PSH_CODE_MAX)
                codeOk = 1'b0;
            if (t[0] && !g)
                codeOk = 1'b0;
            if (t < `PSH_HIGH_FIRST && t != m)
                codeOk = 1'b0;
            if (t >= `PSH_HIGH_FIRST && vco(m) > `PSH_VCO_PORTAL &&
                vco(t) + `PSH_VCO_STEP < vco(m))
                codeOk = 1'b0;
        end
    endfunction

    // Control word for the next step, chosen from a completed status read
    always @* begin
        next_ctl = 64'h0;
        next_ctl[`PSH_CTL_START] = 1'b1;
        next_ctl[36:32] = 5'h00;
        next_ctl[51:32] = mpSys ? `PSH_MP_SGCOUNT : sgCount;
        if (curV != tgtVolt) begin
            next_ctl[12:8] = tgtVolt;
            next_ctl[5:0]  = curF;
        end else begin
            next_ctl[12:8] = curV;
            next_ctl[5:0]  = stepTo(curF, tgtFreq);
        end
    end

    // APB slave, answers one cycle into the access phase
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            pready   <= 1'b0;
            pslverr  <= 1'b0;
            prdata   <= 32'h0;
            mpSys    <= 1'b0;
            dualCore <= 1'b0;
            revG     <= 1'b0;
            osDone   <= 1'b0;
            tgtFreq  <= `PSH_RST_TGTFREQ;
            tgtVolt  <= `PSH_RST_VOLT;
            minCode  <= `PSH_RST_MINCODE;
            sgCount  <= `PSH_RST_TIMEOUT;
        end else if (clkEn) begin
            pready  <= psel & penable & ~pready;
            pslverr <= 1'b0;
            if (psel & penable & ~pready) begin
                prdata <= 32'h0;
                case (paddr)
                    `PSH_OFF_CTRL:
                        prdata <= {27'h0, osDone, revG, dualCore,
                                   mpSys, 1'b0};
                    `PSH_OFF_TARGET:
                        prdata <= {10'h0, minCode, 3'h0, tgtVolt,
                                   2'h0, tgtFreq};
                    `PSH_OFF_TIMEOUT:
                        prdata <= {12'h0, sgCount};
                    `PSH_OFF_STATUS:
                        prdata <= {11'h0, presVolt, 2'h0, presFreq,
                                   5'h0, state};
                    default:
                        pslverr <= 1'b1;
                endcase
                if (paddr == `PSH_OFF_STATUS)
                    prdata[2:0] <= {refused, done, busy};
            end
            // Settings are frozen while a change is running
            if (apbWr && !busy) begin
                case (paddr)
                    `PSH_OFF_CTRL: begin
                        mpSys    <= pwdata[`PSH_CTRL_MP];
                        dualCore <= pwdata[`PSH_CTRL_DUAL];
                        revG     <= pwdata[`PSH_CTRL_REVG];
                    end
                    `PSH_OFF_TARGET: begin
                        tgtFreq <= pwdata[`PSH_TGT_FREQ_LSB +: 6];
                        tgtVolt <= pwdata[`PSH_TGT_VOLT_LSB +: 5];
                        minCode <= pwdata[`PSH_TGT_MIN_LSB +: 6];
                    end
                    `PSH_OFF_TIMEOUT:
                        sgCount <= pwdata[19:0];
                    default: ;
                endcase
            end
            // Handoff is sticky until reset
            if (apbWr && paddr == `PSH_OFF_CTRL && pwdata[`PSH_CTRL_OSDONE])
                osDone <= 1'b1;
        end
    end

    // Sequencer for device register accesses
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state    <= ST_IDLE;
            busy     <= 1'b0;
            done     <= 1'b0;
            refused  <= 1'b0;
            presFreq <= `PSH_RST_MINCODE;
            presVolt <= `PSH_RST_VOLT;
            devReq   <= 1'b0;
            devWrite <= 1'b0;
            devAddr  <= 32'h0;
            devWdata <= 64'h0;
        end else if (clkEn) begin
            case (state)
                ST_IDLE: begin
                    if (goPulse && !busy) begin
                        done <= 1'b0;
                        if (goOs ||
                            !codeOk(tgtFreq, minCode, goRevG)) begin
                            refused <= 1'b1;
                        end else begin
                            refused  <= 1'b0;
                            busy     <= 1'b1;
                            devReq   <= 1'b1;
                            devWrite <= 1'b1;
                            devWdata <= `PSH_CORE1_VALUE;
                            devAddr  <= `PSH_DEV_CORE1;
                            state    <= ST_CORE1;
                            if (!goDual) begin
                                devWrite <= goMp;
                                devWdata <= goMp ? `PSH_REQEN_VALUE
                                                 : 64'h0;
                                devAddr  <= goMp ? `PSH_DEV_REQEN
                                                 : `PSH_DEV_STAT;
                                state    <= goMp ? ST_REQEN : ST_READ;
                            end
                        end
                    end
                end
                ST_CORE1: begin
                    if (devAck) begin
                        devWrite <= mpSys;
                        devWdata <= mpSys ? `PSH_REQEN_VALUE : 64'h0;
                        devAddr  <= mpSys ? `PSH_DEV_REQEN
                                          : `PSH_DEV_STAT;
                        state    <= mpSys ? ST_REQEN : ST_READ;
                    end
                end
                ST_REQEN: begin
                    if (devAck) begin
                        devWdata <= `PSH_CLKTIM_VALUE;
                        devAddr  <= `PSH_DEV_CLKTIM;
                        state    <= ST_CLKTM;
                    end
                end
                ST_CLKTM: begin
                    if (devAck) begin
                        devWrite <= 1'b0;
                        devWdata <= 64'h0;
                        devAddr  <= `PSH_DEV_STAT;
                        state    <= ST_READ;
                    end
                end
                ST_READ: begin
                    // Keep reading while a change is pending
                    if (devAck && !devRdata[`PSH_STAT_PEND]) begin
                        presFreq <= curF;
                        presVolt <= curV;
                        if (curV == tgtVolt && curF == tgtFreq) begin
                            devReq <= 1'b0;
                            busy   <= 1'b0;
                            done   <= 1'b1;
                            state  <= ST_IDLE;
                        end else begin
                            devWrite <= 1'b1;
                            devAddr  <= `PSH_DEV_CTL;
                            devWdata <= next_ctl;
                            state    <= ST_WRITE;
                        end
                    end
                end
                ST_WRITE: begin
                    if (devAck) begin
                        devWrite <= 1'b0;
                        devWdata <= 64'h0;
                        devAddr  <= `PSH_DEV_STAT;
                        state    <= ST_READ;
                    end
                end
                default: begin
                    devReq <= 1'b0;
                    busy   <= 1'b0;
                    state  <= ST_IDLE;
                end
            endcase
        end
    end

endmodule

// ### src/psh_defs.vh
// Constants for the performance-state host controller.
// Assumes inclusion by bare name from the controller source.
`ifndef PSH_DEFS_VH
`define PSH_DEFS_VH

// Own register offsets on the APB side
`define PSH_OFF_CTRL      12'h000
`define PSH_OFF_TARGET    12'h004
`define PSH_OFF_TIMEOUT   12'h008
`define PSH_OFF_STATUS    12'h00C

// Control register bits
`define PSH_CTRL_GO       0
`define PSH_CTRL_MP       1
`define PSH_CTRL_DUAL     2
`define PSH_CTRL_REVG     3
`define PSH_CTRL_OSDONE   4

// Target register fields
`define PSH_TGT_FREQ_LSB  0
`define PSH_TGT_VOLT_LSB  8
`define PSH_TGT_MIN_LSB   16

// Reset values
`define PSH_RST_TARGET    32'h00000000
`define PSH_RST_TIMEOUT   20'h00001
`define PSH_RST_MINCODE   6'h00
`define PSH_RST_TGTFREQ   6'h00
`define PSH_RST_VOLT      5'h00

// Device register addresses
`define PSH_DEV_CORE1     32'h00000068
`define PSH_DEV_REQEN     32'h0000006C
`define PSH_DEV_CLKTIM    32'h000000D8
`define PSH_DEV_CTL       32'hC0010041
`define PSH_DEV_STAT      32'hC0010042

// Device register fields and fixed values
`define PSH_CTL_START     16
`define PSH_STAT_PEND     31
`define PSH_CORE1_VALUE   64'h0000000000000001
`define PSH_REQEN_VALUE   64'h0000000000000001
`define PSH_CLKTIM_VALUE  64'h0000000020002710
`define PSH_MP_SGCOUNT    20'h00001

// Frequency code limits, VCO in 100 MHz units
`define PSH_HIGH_FIRST    6'h08
`define PSH_CODE_MAX      6'h2A
`define PSH_VCO_PORTAL    7'h10
`define PSH_VCO_STEP      7'h02
`define PSH_VCO_OFFSET    7'h08

`endif

// ### sim/psh_controller_assertions.sv
// Checker for the host controller's APB and device port.
// Assumes it is bound to psh_controller with clkEn held high.
`timescale 1ns/1ps
`include "psh_defs.vh"
module psh_controller_assertions (
    input wire        ref_clk,
    input wire        resetn,
    input wire        clkEn,
    input wire [11:0] paddr,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire        devReq,
    input wire        devWrite,
    input wire [31:0] devAddr,
    input wire [63:0] devWdata,
    input wire [63:0] devRdata,
    input wire        devAck
);
    // Oscillator rate in 100 MHz units
    function automatic [6:0] vco(input [5:0] c);
        vco = (c < 6'h08) ? {c, 1'b0} + 7'h10 : {1'b0, c} + 7'h08;
    endfunction
    reg  [5:0] curFid;
    reg  [4:0] ctrlBits;
    wire       ctlWr = devReq && devWrite && devAddr == `PSH_DEV_CTL;
    wire [6:0] vNew = vco(devWdata[5:0]);
    wire [6:0] vCur = vco(curFid);
    wire       stepOk = ((vNew > vCur) ? vNew - vCur : vCur - vNew) <= 7'h02;
    // Last code read back and last control settings written
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            curFid <= 6'h00;
            ctrlBits <= 5'h00;
        end else begin
            if (devAck && !devWrite && devAddr == `PSH_DEV_STAT)
                curFid <= devRdata[5:0];
            if (psel && penable && pready && pwrite && paddr == 12'h000)
                ctrlBits <= pwdata[4:0] | {ctrlBits[4], 4'h0};
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    AST_ONE_WAIT: assert property (psel && penable && !pready |=> pready)
        else $error("APB answer not after one wait");
    AST_RESET_IDLE: assert property ($rose(resetn) |-> !devReq && !pready)
        else $error("busy right after reset");
    AST_DEV_HOLD: assert property (devReq && !devAck |=>
        devReq && $stable(devAddr) && $stable(devWdata) && $stable(devWrite))
        else $error("device request dropped before ack");
    AST_START_WORD: assert property (ctlWr |-> devWdata[16] &&
        devWdata[63:52] == 12'h000 && devWdata[31:17] == 15'h0000)
        else $error("bad control word");
    AST_STEP_LIMIT: assert property (ctlWr |-> stepOk)
        else $error("oscillator step above limit");
    AST_MP_COUNT: assert property (ctlWr && ctrlBits[1] |->
        devWdata[51:32] == 20'h00001)
        else $error("stop-grant count not one");
    AST_DUAL_FIRST: assert property ($rose(devReq) && ctrlBits[2] |->
        devWrite && devAddr == `PSH_DEV_CORE1)
        else $error("second core not enabled first");
    AST_NO_OS: assert property (!devReq && (ctrlBits[4] || (psel &&
        penable && pready && pwrite && paddr == 12'h000 && pwdata[4]))
        |=> !devReq)
        else $error("change started after handoff");
    cover property (ctlWr && devAck);
    cover property (pslverr);
    cover property ($rose(devReq) && ctrlBits[2]);
endmodule

// ### sim/psh_device_model.sv
// Behavioural model of the core's state registers on the device port.
// Assumes a held request that the model completes with a one-cycle ack.
`timescale 1ns/1ps
`include "psh_defs.vh"
module psh_device_model #(
    parameter [4:0] START_VOLT = 5'h12
) (
    input  wire        ref_clk,
    input  wire        resetn,
    input  wire [3:0]  lat,
    input  wire        devReq,
    input  wire        devWrite,
    input  wire [31:0] devAddr,
    input  wire [63:0] devWdata,
    output reg  [63:0] devRdata,
    output reg         devAck
);
    // Oscillator rate, 100 MHz units; low codes run it at twice core
    function automatic [6:0] vco(input [5:0] c);
        vco = (c < 6'h08) ? {c, 1'b0} + 7'h10 : {1'b0, c} + 7'h08;
    endfunction
    reg  [5:0]  freq_code, target_freq_code;
    reg  [4:0]  volt_code, target_volt_code;
    reg  [1:0]  pend;
    reg  [3:0]  cnt;
    reg  [7:0]  nWr, nBad;
    reg  [63:0] lastCtl;
    reg  [31:0] core1, reqEn, clkTim;
    wire [6:0]  vA = vco(freq_code);
    wire [6:0]  vB = vco(devWdata[5:0]);
    wire        big = ((vA > vB) ? vA - vB : vB - vA) > 7'h02;
    wire        both = devWdata[5:0] != freq_code && devWdata[12:8] != volt_code;
    // Access handling, state change after two pending reads
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            freq_code <= `PSH_RST_MINCODE;
            volt_code <= START_VOLT;
            {target_freq_code, target_volt_code, pend, cnt, nWr, nBad} <= 33'h0;
            {lastCtl, core1, reqEn, clkTim, devRdata, devAck} <= 225'h0;
        end else begin
            devAck <= 1'b0;
            devRdata <= ~devRdata; // Released bus keeps no stale value
            if (devReq && !devAck && cnt < lat) begin
                cnt <= cnt + 4'h1;
            end else if (devReq && !devAck) begin
                cnt <= 4'h0;
                devAck <= 1'b1;
                if (devWrite && devAddr == `PSH_DEV_CORE1) core1 <= devWdata[31:0];
                if (devWrite && devAddr == `PSH_DEV_REQEN) reqEn <= devWdata[31:0];
                if (devWrite && devAddr == `PSH_DEV_CLKTIM) clkTim <= devWdata[31:0];
                if (devWrite && devAddr == `PSH_DEV_CTL && devWdata[16]) begin
                    lastCtl <= devWdata;
                    nWr <= nWr + 8'h1;
                    nBad <= nBad + {7'h0, big | both};
                    target_freq_code <= devWdata[5:0];
                    target_volt_code <= devWdata[12:8];
                    pend <= 2'h2;
                end
                if (!devWrite && devAddr == `PSH_DEV_STAT) begin
                    devRdata <= {27'h0, volt_code, pend != 2'h0, 25'h0, freq_code};
                    if (pend != 2'h0) pend <= pend - 2'h1;
                    if (pend == 2'h1) begin
                        freq_code <= target_freq_code;
                        volt_code <= target_volt_code;
                    end
                end
            end
        end
    end
endmodule

// ### sim/psh_controller_tb.sv
// Self-checking bench: APB stimulus, device model on the far side.
// Assumes a 100 MHz clock and the controller's own register map.
`timescale 1ns/1ps
`include "psh_defs.vh"
module psh_controller_tb;
    reg         ref_clk, resetn, clkEn, psel, penable, pwrite, err;
    reg  [11:0] paddr;
    reg  [31:0] pwdata, rd;
    reg  [3:0]  lat;
    wire [31:0] prdata, devAddr;
    wire        pready, pslverr, devReq, devWrite, devAck;
    wire [63:0] devWdata, devRdata;
    integer     n_errors, n_compared;
    localparam [127:0] BAD = {32'h00070A0E, 32'h00000A03, 32'h00000A2B,
        32'h00000A0D};
    psh_controller i_dut (.ref_clk(ref_clk), .resetn(resetn), .clkEn(clkEn),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .devReq(devReq), .devWrite(devWrite), .devAddr(devAddr),
        .devWdata(devWdata), .devRdata(devRdata), .devAck(devAck));
    psh_device_model i_dev (.ref_clk(ref_clk), .resetn(resetn), .lat(lat),
        .devReq(devReq), .devWrite(devWrite), .devAddr(devAddr),
        .devWdata(devWdata), .devRdata(devRdata), .devAck(devAck));
    // Free-running clock
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    task chk(input [63:0] got, input [63:0] exp);
        n_compared = n_compared + 1;
        if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One APB transfer, held until pready is sampled high
    task apb(input w, input [11:0] a, input [31:0] d);
        integer k;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge ref_clk);
            k = k + 1;
        end while (pready !== 1'b1 && k < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 50) chk(64'h0, 64'h1);
    endtask
    // Program target, start, poll status until not busy
    task run_go(input [31:0] tgt, input [4:0] ctl);
        integer k;
        apb(1'b1, `PSH_OFF_TARGET, tgt);
        apb(1'b1, `PSH_OFF_CTRL, {27'h0, ctl});
        k = 0;
        rd = 32'h1;
        while (rd[0] !== 1'b0 && k < 300) begin
            apb(1'b0, `PSH_OFF_STATUS, 32'h0);
            k = k + 1;
        end
        if (k >= 300) chk(64'h0, 64'h1);
    endtask
    task sc_reset;
        apb(1'b0, `PSH_OFF_STATUS, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, `PSH_OFF_TIMEOUT, 32'h0);
        chk(rd, 32'h1);
        chk(i_dev.freq_code, 6'h00);
        apb(1'b0, 12'h010, 32'h0);
        chk({err, rd}, {1'b1, 32'h0});
    endtask
    task sc_up;
        lat <= 4'h5;
        apb(1'b1, `PSH_OFF_TIMEOUT, 32'h190);
        run_go(32'h00000A0C, 5'h01);
        chk(rd[20:0], 21'h0A0C02);
        chk(i_dev.freq_code, 6'h0C);
        chk(i_dev.nWr, 8'h03);
        chk(i_dev.lastCtl[51:32], 20'h00190);
    endtask
    task sc_refuse;
        integer i;
        for (i = 0; i < 4; i = i + 1) begin
            run_go(BAD[i*32 +: 32], 5'h01);
            chk(rd[2], 1'b1);
            chk(i_dev.nWr, 8'h03);
        end
        chk(i_dev.freq_code, 6'h0C);
    endtask
    task sc_mp;
        lat <= 4'h0;
        run_go(32'h00000A0D, 5'h0F);
        chk(i_dev.freq_code, 6'h0D);
        chk({i_dev.core1, i_dev.reqEn}, 64'h0000000100000001);
        chk(i_dev.clkTim, 32'h20002710);
        chk(i_dev.lastCtl[51:32], 20'h00001);
        run_go(32'h00000A00, 5'h0B);
        chk(i_dev.freq_code, 6'h00);
        chk(i_dev.nBad, 8'h00);
    endtask
    task sc_os;
        run_go(32'h00000A0C, 5'h11);
        chk(rd[2], 1'b1);
        chk(i_dev.freq_code, 6'h00);
        run_go(32'h00000A0C, 5'h01);
        chk(rd[2], 1'b1);
        chk(i_dev.nWr, 8'h07);
    endtask
    task complete_run;
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Main sequence
    initial begin
        n_errors = 0;
        n_compared = 0;
        {resetn, psel, penable, pwrite, paddr, pwdata, lat} = 0;
        clkEn = 1'b1;
        repeat (10) @(posedge ref_clk);
        resetn <= 1'b1;
        sc_reset;
        sc_up;
        sc_refuse;
        sc_mp;
        sc_os;
        complete_run;
    end
    // Watchdog
    initial begin
        #200000;
        n_errors = n_errors + 1;
        complete_run;
    end
endmodule
bind psh_controller psh_controller_assertions i_chk (.ref_clk(ref_clk),
    .resetn(resetn), .clkEn(clkEn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .devReq(devReq),
    .devWrite(devWrite), .devAddr(devAddr), .devWdata(devWdata),
    .devRdata(devRdata), .devAck(devAck));
